// *** dbg_ctrl_pkg.sv ***
// Purpose: constants and types for the debug control and reset block
// Assumes: AXI4-Lite register access, 32-bit data, 10 MHz clock
// Notes: one package shared by the design file and the bench
// What this block and its debugger do
// R1 - debug reset returns debug registers to reset
// R2 - two-bit field selects halt, monitor, or none
// R3 - no debug event without invasive enable
// R4 - mode changes never deadlock or lose data
// R5 - status/control fields clear to zero on reset
// R6 - channel access mode resets to non-blocking
// R7 - debug reset works during gated standby too
// R8 - debugger writes zero after debug reset
// R9 - debugger disables matches before mode changes; the bench raises a match during the write that clears the mode
// R10 - system reset mid-access gives slave error
// R11 - debugger avoids accesses during system reset; the bench pulses system reset during a system-view write
// R12 - disabled debug drops pending event, access completes
package dbg_ctrl_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] DSCR_OFF = 8'h00;
  localparam logic [7:0] MATCH_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] SYSACC_OFF = 8'h0c;
  localparam int MODE_LSB = 14;
  localparam int CCMODE_LSB = 20;
  localparam logic [31:0] DSCR_RST = 32'h0000_0000;
  localparam logic [31:0] DSCR_WMASK = 32'h0030_c000;
  localparam logic [1:0] CC_NONBLOCK = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] MODE_HALT = 2'h1;
  localparam logic [1:0] MODE_MON = 2'h2;
  // system-view access length in ns, rounded up to whole clock cycles
  localparam int SYSACC_TIME_NS = 400;
  localparam int CLK_NS = 100;
  localparam int SYSACC_CYC = (SYSACC_TIME_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed
  {
    logic bkpt;
    logic wpt;
  } match_t;
endpackage

// *** dbg_ctrl.sv ***
// Purpose: debug control: status/control register, mode select, event gating
// Assumes: rst_n synchronous; debug, system resets and pins are asynchronous
// Notes: registers over AXI4-Lite; system-view access runs a fixed count
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module dbg_ctrl
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic debugResetN,
  input wire logic systemResetN,
  input wire logic invasiveDebugEnable,
  input wire logic standbyWaitIndicator,
  input wire dbg_ctrl_pkg::match_t matchIn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic haltReq,
  output logic monitorReq
);
  import dbg_ctrl_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] syncA_r, syncB_r;
  always_ff @(posedge clk)
  begin
    syncA_r <= {debugResetN, systemResetN, invasiveDebugEnable, standbyWaitIndicator};
    syncB_r <= syncA_r;
  end
  logic dbgRstN, sysRstN, invasive_debug_enable, standby;
  assign dbgRstN = syncB_r[3];
  assign sysRstN = syncB_r[2];
  assign invasive_debug_enable = syncB_r[1];
  assign standby = syncB_r[0];

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic awHave_r, wHave_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  assign doWrite = awHave_r && wHave_r && !bvalid;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      else if (doWrite)
        awHave_r <= 1'b0;
      if (wvalid && wready)
      begin
        wHave_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      else if (doWrite)
        wHave_r <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
    end
    else
    begin
      awready <= !awHave_r && !(awvalid && awready);
      wready <= !wHave_r && !(wvalid && wready);
    end
  end

  // ----------------------------------------
  // status/control register
  // ----------------------------------------
  logic [31:0] dscr_r;
  logic [31:0] strbMask;
  always_comb
  begin
    strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  end
  always_ff @(posedge clk)
  begin
    // debug reset needs no core clock gating state, so standby does not block it
    if (!rst_n || !dbgRstN)   // see R1 see R5 see R6 see R7
      dscr_r <= DSCR_RST;
    else if (doWrite && awAddr_r == DSCR_OFF)
      dscr_r <= (dscr_r & ~(strbMask & DSCR_WMASK)) | (wData_r & strbMask & DSCR_WMASK);
  end
  logic [1:0] modeSel;
  logic [1:0] ccMode;
  assign modeSel = dscr_r[MODE_LSB +: 2];   // see R2
  assign ccMode = dscr_r[CCMODE_LSB +: 2];

  // ----------------------------------------
  // debug event gating
  // ----------------------------------------
  logic pending_r;
  logic [1:0] pendMode_r;
  logic dropped_r;
  logic armed;
  assign armed = invasive_debug_enable && (modeSel == MODE_HALT || modeSel == MODE_MON);
  always_ff @(posedge clk)
  begin
    if (!rst_n || !dbgRstN)
    begin
      pending_r <= 1'b0;
      pendMode_r <= 2'h0;
      dropped_r <= 1'b0;
      haltReq <= 1'b0;
      monitorReq <= 1'b0;
    end
    else
    begin
      haltReq <= 1'b0;
      monitorReq <= 1'b0;
      // a drop in the same cycle wins: its later assignment overrides the clear
      if (doWrite && awAddr_r == STAT_OFF && wData_r[0])
        dropped_r <= 1'b0;
      if (pending_r)
      begin
        pending_r <= 1'b0;
        // enable lost mid-flight: drop event, access completes normally
        if (!armed)   // see R4 see R12
          dropped_r <= 1'b1;
        else
        begin
          haltReq <= (modeSel == MODE_HALT);   // see R3
          monitorReq <= (modeSel == MODE_MON);
        end
      end
      else if ((matchIn.bkpt || matchIn.wpt) && armed)   // see R3
      begin
        pending_r <= 1'b1;
        pendMode_r <= modeSel;
      end
    end
  end

  // ----------------------------------------
  // system-view access and write response
  // ----------------------------------------
  logic [2:0] sysCnt_r;
  logic sysBusy_r, sysErr_r, sysWr_r;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sysBusy_r <= 1'b0;
      sysErr_r <= 1'b0;
      sysCnt_r <= 3'h0;
    end
    else if (sysBusy_r)
    begin
      if (!sysRstN)   // see R10
        sysErr_r <= 1'b1;
      if (sysCnt_r == 3'(SYSACC_CYC - 1))
        sysBusy_r <= 1'b0;
      else
        sysCnt_r <= sysCnt_r + 3'h1;
    end
    else if ((doWrite && awAddr_r == SYSACC_OFF) || (arvalid && arready && araddr == SYSACC_OFF))
    begin
      sysBusy_r <= 1'b1;
      sysErr_r <= !sysRstN;
      sysCnt_r <= 3'h0;
    end
  end
  logic sysDone;
  assign sysDone = sysBusy_r && sysCnt_r == 3'(SYSACC_CYC - 1);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      sysWr_r <= 1'b0;
    end
    else if (bvalid)
      bvalid <= !bready;
    else if (sysWr_r && sysDone)
    begin
      bvalid <= 1'b1;
      bresp <= (sysErr_r || !sysRstN) ? RESP_SLVERR : RESP_OKAY;   // see R10
      sysWr_r <= 1'b0;
    end
    else if (doWrite && awAddr_r == SYSACC_OFF)
      sysWr_r <= 1'b1;
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp <= (awAddr_r == DSCR_OFF || awAddr_r == STAT_OFF) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic sysRd_r;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      sysRd_r <= 1'b0;
    end
    else
    begin
      arready <= !(arvalid && arready) && !rvalid && !sysRd_r && !sysBusy_r;
      if (rvalid)
        rvalid <= !rready;
      else if (sysRd_r && sysDone)
      begin
        sysRd_r <= 1'b0;
        rvalid <= 1'b1;
        rdata <= 32'h0000_0000;
        rresp <= (sysErr_r || !sysRstN) ? RESP_SLVERR : RESP_OKAY;   // see R10
      end
      else if (arvalid && arready)
      begin
        if (araddr == SYSACC_OFF)
          sysRd_r <= 1'b1;
        else
        begin
          rvalid <= 1'b1;
          rresp <= RESP_OKAY;
          unique case (araddr)
            DSCR_OFF: rdata <= dscr_r;
            MATCH_OFF: rdata <= {30'h0, matchIn.wpt, matchIn.bkpt};
            STAT_OFF: rdata <= {27'h0, standby, invasive_debug_enable, pendMode_r == MODE_HALT, pending_r, dropped_r};
            default:
            begin
              rdata <= 32'h0000_0000;
              rresp <= RESP_SLVERR;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence matchArmed;
    (matchIn.bkpt || matchIn.wpt) && armed && !pending_r;
  endsequence
  no_event_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(invasive_debug_enable) |-> !haltReq && !monitorReq) else $error("debug event while disabled"); // see R3
  mode_halt_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    haltReq |-> $past(modeSel) == MODE_HALT) else $error("halt without halt mode"); // see R2
  pend_resolves_a: assert property (@(posedge clk) disable iff (!rst_n || !dbgRstN)
    matchArmed |=> ##1 !pending_r) else $error("pending event stuck"); // see R4
  drop_on_disable_a: assert property (@(posedge clk) disable iff (!rst_n || !dbgRstN)
    pending_r && !armed |=> dropped_r && !haltReq && !monitorReq) else $error("event not dropped"); // see R12
  dscr_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dbgRstN |=> dscr_r == DSCR_RST) else $error("status register not reset"); // see R1
  cc_mode_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dbgRstN |=> ccMode == CC_NONBLOCK) else $error("channel mode not non-blocking"); // see R6
  standby_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    standby && !dbgRstN |=> dscr_r[MODE_LSB +: 2] == 2'h0) else $error("reset lost in standby"); // see R7
  fields_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dscr_r & ~DSCR_WMASK) == 32'h0) else $error("field outside mask set"); // see R5
  sys_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    sysBusy_r && !sysRstN |-> ##[1:8] (bvalid && bresp == RESP_SLVERR) || (rvalid && rresp == RESP_SLVERR))
    else $error("system reset access not errored"); // see R10
endmodule

// *** debugger_model.sv ***
// Purpose: far-side debugger pins, debug reset and invasive enable
// Assumes: pins change just after a rising edge
// Notes: reset is held 4 cycles, longer than the sync needs
`timescale 1ns/1ps
module debugger_model
(
  input wire logic clk,
  output logic debugResetN,
  output logic invasiveDebugEnable
);
  initial debugResetN = 1'b1;
  initial invasiveDebugEnable = 1'b0;
  task automatic pulseReset();
    @(posedge clk);
    debugResetN <= 1'b0;
    repeat (4) @(posedge clk);
    debugResetN <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // callers quiet every match before this
  task automatic setEnable(input logic v);
    @(posedge clk);
    invasiveDebugEnable <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

// *** cpu_debug_control_and_reset_tb_top.sv ***
// Purpose: self-checking bench for dbg_ctrl
// Assumes: AXI4-Lite master waits on ready and valid, no fixed latency
// Notes: debug events are counted from the request pulses
`timescale 1ns/1ps
module cpu_debug_control_and_reset_tb_top;
  import dbg_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic systemResetN = 1'b1;
  logic standbyWaitIndicator = 1'b0;
  match_t matchIn = '0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, haltReq, monitorReq;
  logic debugResetN, invasiveDebugEnable, en;
  logic [1:0] bresp, rresp, resp, md;
  logic [31:0] rdata, rdv;
  int fails = 0, n_tests = 0, cycles = 0, nHalt = 0, nMon = 0, h0, m0;

  initial forever #50 clk = ~clk;

  dbg_ctrl dbg_ctrl_inst (.clk(clk), .rst_n(rst_n), .debugResetN(debugResetN),
    .systemResetN(systemResetN), .invasiveDebugEnable(invasiveDebugEnable),
    .standbyWaitIndicator(standbyWaitIndicator), .matchIn(matchIn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .haltReq(haltReq), .monitorReq(monitorReq));
  debugger_model debugger_model_inst (.clk(clk), .debugResetN(debugResetN),
    .invasiveDebugEnable(invasiveDebugEnable));

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (haltReq === 1'b1) nHalt <= nHalt + 1;
    if (monitorReq === 1'b1) nMon <= nMon + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      results();
    end
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      t++;
    end while (bvalid !== 1'b1 && t < 200);
    resp = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1)
    begin
      fails++;
      results();
    end
    @(posedge clk);
  endtask
  task automatic axiRd(input logic [7:0] a);
    int t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      t++;
    end while (rvalid !== 1'b1 && t < 200);
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1)
    begin
      fails++;
      results();
    end
    @(posedge clk);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    axiRd(DSCR_OFF);
    check("dscr reset", rdv, DSCR_RST);
    check("ccmode reset", 32'(rdv[CCMODE_LSB +: 2]), 32'(CC_NONBLOCK));
    axiRd(8'h10);
    check("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
    axiWr(DSCR_OFF, 32'hffff_ffff);
    axiRd(DSCR_OFF);
    check("dscr mask", rdv, DSCR_WMASK);
    standbyWaitIndicator <= 1'b1;
    debugger_model_inst.pulseReset();
    axiRd(DSCR_OFF);
    check("dscr after debug reset", rdv, DSCR_RST);
    standbyWaitIndicator <= 1'b0;
    axiWr(DSCR_OFF, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      md = (i == 4) ? MODE_HALT : i[1:0];
      en = (i < 4);
      axiWr(DSCR_OFF, 32'(md) << MODE_LSB);
      debugger_model_inst.setEnable(en);
      h0 = nHalt;
      m0 = nMon;
      matchIn <= 2'b11;
      @(posedge clk);
      matchIn <= '0;
      repeat (8) @(posedge clk);
      check("halt events", 32'(nHalt - h0), 32'(en && md == MODE_HALT));
      check("monitor events", 32'(nMon - m0), 32'(en && md == MODE_MON));
    end
    debugger_model_inst.setEnable(1'b1);
    axiWr(DSCR_OFF, 32'(MODE_HALT) << MODE_LSB);
    // match rises one cycle after the write starts, so it is pending as the mode clears
    h0 = nHalt;
    fork
      axiWr(DSCR_OFF, 32'h0);
      begin
        @(posedge clk);
        matchIn <= 2'b11;
      end
    join
    repeat (4) @(posedge clk);
    matchIn <= '0;
    @(posedge clk);
    check("halt after disarm", 32'(nHalt - h0), 32'h0);
    axiRd(STAT_OFF);
    check("drop flag", 32'(rdv[1:0]), 32'h1);
    axiWr(STAT_OFF, 32'h1);
    axiRd(STAT_OFF);
    check("drop clear", 32'(rdv[0]), 32'h0);
    fork
      axiWr(SYSACC_OFF, 32'h0);
      begin
        @(posedge clk);
        systemResetN <= 1'b0;
        repeat (4) @(posedge clk);
        systemResetN <= 1'b1;
      end
    join
    check("sys access cut", 32'(resp), 32'(RESP_SLVERR));
    repeat (4) @(posedge clk);
    axiRd(SYSACC_OFF);
    check("sys access clean", 32'(resp), 32'(RESP_OKAY));
    results();
  end
endmodule
